//--- hdl/palette_dac_host_register_port.sv
// Host register port of a palette video converter: registers and palettes.
// Host pins are asynchronous and are resynchronised to clk here.
`timescale 1ns/1ns
`default_nettype none
module palette_dac_host_register_port import dac_port_pkg::*; #(
  parameter int         PAL_DEPTH = 256,
  parameter logic [7:0] ID_CODE   = 8'h5a  // Arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire host_pins_t host_in,
  input  wire logic [1:0] palette_sel_in,
  input  wire pixel_t     pixel_in,
  output logic [9:0]      data_out,
  output logic            data_oe_n,
  output logic            video_enable,
  output logic            seq_restart,
  output logic            cal_start,
  output logic            dac_depth_sel,
  output logic [5:0]      prog_clock_div,
  output logic [5:0]      load_clock_div,
  output pixel_t          pixel_masked
);

  localparam int PW = $clog2(PAL_DEPTH);

  typedef struct packed {
    host_pins_t                      s1;
    host_pins_t                      s2;
    logic                            ce_n_prev;
    logic [1:0]                      ps_s1;
    logic [1:0]                      ps_s2;
    logic                            por;
    logic [3:0]                      por_cnt;
    logic                            busy;
    logic                            drive;
    logic [9:0]                      rd_data;
    logic [9:0]                      wdat;
    reg_sel_t                        acc_sel;
    logic                            acc_rd;
    logic                            acc_hi;
    logic                            idx_hi_next;
    logic                            idx_last_rd;
    col_ptr_t                        col;
    logic                            half;
    logic [9:0]                      cval;
    logic [9:0]                      red;
    logic [9:0]                      green;
    logic [10:0]                     idx;
    logic [9:0]                      mode;
    logic [9:0]                      cr1;
    logic [9:0]                      cr2;
    logic [9:0]                      cr3;
    logic [9:0]                      cr4;
    logic [9:0]                      cr5;
    logic [7:0]                      mask;
    logic [2:0]                      seq_hist;
    logic                            seq_pulse;
    logic                            cal_pulse;
    logic                            video_en;
    logic [5:0]                      prg_div_q;
    logic [5:0]                      load_div_q;
    pixel_t                          pix;
    logic [PAL_DEPTH-1:0][29:0]      pal;
    logic [3:0][29:0]                ovl;
    logic [1:0][29:0]                ccol;
  } state_t;

  function automatic state_t init_state();
    state_t s;
    s             = '0;
    s.s1.ce_n     = 1'b1;
    s.s2.ce_n     = 1'b1;
    s.ce_n_prev   = 1'b1;
    s.por         = 1'b1;
    s.col         = COL_RED;
    s.idx         = 11'h000;
    s.mode        = MODE_RST;
    s.cr1         = CR_ZERO;
    s.cr2         = CR2_RST;
    s.cr3         = CR3_RST;
    s.cr4         = CR_ZERO;
    s.cr5         = CR_ZERO;
    s.seq_hist    = 3'h7;
    s.prg_div_q   = POR_PRG_DIV;
    s.load_div_q  = POR_LOAD_DIV;
    return s;
  endfunction

  localparam state_t ST_RST = init_state();

  state_t      q;
  state_t      n;
  logic        ce_fall;
  logic        ce_rise;
  logic        split;
  logic [9:0]  bus_data;
  logic [9:0]  full_val;
  logic [9:0]  chan_val;
  logic        chan_done;
  logic        hi_now;
  logic        in_pal;
  logic        in_ovl;
  logic        in_ccol;
  logic [29:0] entry;
  logic [9:0]  chan_rd;
  logic [9:0]  rdv;
  logic        auto_inc;

  // ==========================================================
  // Next state
  always_comb begin
    n           = q;
    n.s1        = host_in;
    n.s2        = q.s1;
    n.ce_n_prev = q.s2.ce_n;
    n.ps_s1     = palette_sel_in;
    n.ps_s2     = q.ps_s1;
    n.seq_pulse = 1'b0;
    n.cal_pulse = 1'b0;

    // Write data sampled while the strobe is low; by the synced rise
    // the pins may already show the host's next bus value
    if (!q.s2.ce_n) begin
      n.wdat = q.s2.data;
    end

    // Internal reset hold after release
    if (q.por) begin
      if (q.por_cnt == POR_CNT_LAST) begin
        n.por = 1'b0;
      end else begin
        n.por_cnt = 4'(q.por_cnt + 4'h1);
      end
    end
    if (q.por) begin
      n.prg_div_q  = POR_PRG_DIV;
      n.load_div_q = POR_LOAD_DIV;
    end else begin
      n.prg_div_q  = prg_div(q.cr3[CR3_PRG_HI:CR3_PRG_LO]);
      n.load_div_q = load_div(q.cr3[CR3_MUX_HI:CR3_MUX_LO]);
    end

    n.video_en  = (q.ps_s2 == q.mode[MODE_MATCH_HI:MODE_MATCH_LO]);
    n.pix.red   = pixel_in.red & q.mask;
    n.pix.green = pixel_in.green & q.mask;
    n.pix.blue  = pixel_in.blue & q.mask;

    // Strobe edges, ignored while the internal reset holds
    ce_fall = q.ce_n_prev & ~q.s2.ce_n & ~q.por;
    ce_rise = ~q.ce_n_prev & q.s2.ce_n & q.busy;

    split    = ~q.mode[MODE_WIDTH] & q.mode[MODE_DEPTH];
    bus_data = q.mode[MODE_WIDTH] ? q.wdat
                                  : {2'h0, q.wdat[7:0]};
    full_val = q.mode[MODE_DEPTH] ? bus_data
                                  : {bus_data[7:0], 2'h0};
    chan_done = ~split | q.half;
    chan_val  = split ? {q.cval[9:2], bus_data[1:0]} : full_val;

    // Palette region of the current index
    in_pal  = (q.idx <= IDX_PAL_LAST);
    in_ovl  = (q.idx[10:2] == IDX_OVL_BASE[10:2]);
    in_ccol = (q.idx >= IDX_CCOL_LO) && (q.idx <= IDX_CCOL_HI);
    if (in_pal) begin
      entry = q.pal[q.idx[PW-1:0]];
    end else if (in_ovl) begin
      entry = q.ovl[q.idx[1:0]];
    end else if (in_ccol) begin
      entry = q.ccol[~q.idx[0]];
    end else begin
      entry = 30'h0;
    end
    unique case (q.col)
      COL_RED:   chan_rd = entry[29:20];
      COL_GREEN: chan_rd = entry[19:10];
      default:   chan_rd = entry[9:0];
    endcase

    // Read value, captured at the falling strobe edge
    hi_now = q.cr1[CR1_HI_BYTE] & q.idx_hi_next
             & (q.idx_last_rd == q.s2.rd_wr_n);
    unique case (q.s2.sel)
      SEL_INDEX: begin
        rdv = hi_now ? {7'h0, q.idx[10:8]}
                     : {2'h0, q.idx[7:0]};
      end
      SEL_MODE: rdv = q.mode & REG8_MASK;
      SEL_CONTROL: begin
        unique case (q.idx)
          IDX_ID:   rdv = {2'h0, ID_CODE};
          IDX_MASK: rdv = {2'h0, q.mask};
          IDX_CR1:  rdv = q.cr1 & REG8_MASK;
          IDX_CR2:  rdv = q.cr2 & REG8_MASK;
          IDX_CR3:  rdv = q.cr3 & REG8_MASK;
          IDX_CR4:  rdv = q.cr4 & REG8_MASK;
          IDX_CR5:  rdv = q.cr5 & REG8_MASK;
          default:  rdv = 10'h000;
        endcase
      end
      default: begin
        if (split) begin
          rdv = q.half ? {8'h00, chan_rd[1:0]}
                       : {2'h0, chan_rd[9:2]};
        end else if (q.mode[MODE_DEPTH]) begin
          rdv = chan_rd;
        end else begin
          rdv = {2'h0, chan_rd[9:2]};
        end
      end
    endcase
    if (!q.mode[MODE_WIDTH]) begin
      rdv[9:8] = 2'h0;
    end

    auto_inc = ((q.idx >= IDX_AUTO_LO) && (q.idx <= IDX_AUTO_HI))
               || (q.idx >= IDX_CURSOR_LO);

    if (ce_fall) begin
      n.busy    = 1'b1;
      n.acc_sel = q.s2.sel;
      n.acc_rd  = q.s2.rd_wr_n;
      n.acc_hi  = hi_now;
      n.drive   = q.s2.rd_wr_n;
      n.rd_data = rdv;
    end

    // Access completes at the rising strobe edge
    if (ce_rise) begin
      n.busy  = 1'b0;
      n.drive = 1'b0;
      if (q.acc_sel != SEL_INDEX) begin
        n.idx_hi_next = 1'b0;
      end
      unique case (q.acc_sel)
        SEL_INDEX: begin
          n.idx_last_rd = q.acc_rd;
          if (q.acc_hi) begin
            n.idx_hi_next = 1'b0;
            if (!q.acc_rd) begin
              n.idx[10:8] = bus_data[2:0];
            end
          end else begin
            n.idx_hi_next = q.cr1[CR1_HI_BYTE];
            if (!q.acc_rd) begin
              n.idx[7:0] = bus_data[7:0];
              if (!q.cr1[CR1_HI_BYTE]) begin
                n.idx[10:8] = 3'h0;
              end
            end
          end
          if (!q.acc_rd) begin
            n.col  = COL_RED;
            n.half = 1'b0;
          end
        end
        SEL_MODE: begin
          if (!q.acc_rd) begin
            n.mode = bus_data & REG8_MASK;
            n.seq_hist = {q.seq_hist[1:0], bus_data[MODE_SEQ_RESTART]};
            n.seq_pulse = ({q.seq_hist[1:0], bus_data[MODE_SEQ_RESTART]}
                           == SEQ_PATTERN);
            n.cal_pulse = ~q.mode[MODE_CAL] & bus_data[MODE_CAL];
          end
        end
        SEL_CONTROL: begin
          if (!q.acc_rd) begin
            unique case (q.idx)
              IDX_MASK: n.mask = bus_data[7:0];
              IDX_CR1:  n.cr1  = bus_data & REG8_MASK;
              IDX_CR2:  n.cr2  = bus_data & REG8_MASK;
              IDX_CR3:  n.cr3  = bus_data & REG8_MASK;
              IDX_CR4:  n.cr4  = bus_data & REG8_MASK;
              IDX_CR5:  n.cr5  = bus_data & REG8_MASK;
              default:  n.mask = q.mask;
            endcase
          end
          if (auto_inc) begin
            n.idx = 11'(q.idx + 11'h001);
          end
        end
        default: begin
          if (!chan_done) begin
            n.half      = 1'b1;
            n.cval[9:2] = bus_data[7:0];
          end else begin
            n.half = 1'b0;
            unique case (q.col)
              COL_RED: begin
                if (!q.acc_rd) begin
                  n.red = chan_val;
                end
                n.col = COL_GREEN;
              end
              COL_GREEN: begin
                if (!q.acc_rd) begin
                  n.green = chan_val;
                end
                n.col = COL_BLUE;
              end
              default: begin
                n.col = COL_RED;
                if (!q.acc_rd) begin
                  if (in_pal) begin
                    n.pal[q.idx[PW-1:0]] = {q.red, q.green, chan_val};
                  end else if (in_ovl) begin
                    n.ovl[q.idx[1:0]] = {q.red, q.green, chan_val};
                  end else if (in_ccol) begin
                    n.ccol[~q.idx[0]] = {q.red, q.green, chan_val};
                  end
                end
                if (q.idx == IDX_PAL_LAST) begin
                  n.idx = 11'h000;
                end else begin
                  n.idx = 11'(q.idx + 11'h001);
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign data_out       = q.rd_data;
  assign data_oe_n      = ~q.drive;
  assign video_enable   = q.video_en;
  assign seq_restart    = q.seq_pulse | q.por;
  assign cal_start      = q.cal_pulse;
  assign dac_depth_sel  = q.mode[MODE_DEPTH];
  assign prog_clock_div = q.prg_div_q;
  assign load_clock_div = q.load_div_q;
  assign pixel_masked   = q.pix;

endmodule
`default_nettype wire

//--- hdl/dac_port_pkg.sv
// Constants, types and helpers shared by the palette converter host port.
// Assumes a 10 MHz system clock and an asynchronous host parallel bus.
package dac_port_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ        = 10_000_000;
  localparam int POR_TIME_NS   = 1000;
  localparam int POR_CYCLES    = (POR_TIME_NS * (CLK_HZ / 1_000_000)
                                  + 999) / 1000;
  localparam logic [3:0] POR_CNT_LAST = 4'(POR_CYCLES - 1);

  // ==========================================================
  // Index map
  localparam logic [10:0] IDX_ID        = 11'h003;
  localparam logic [10:0] IDX_MASK      = 11'h004;
  localparam logic [10:0] IDX_CR1       = 11'h005;
  localparam logic [10:0] IDX_CR2       = 11'h006;
  localparam logic [10:0] IDX_CR3       = 11'h007;
  localparam logic [10:0] IDX_CR4       = 11'h008;
  localparam logic [10:0] IDX_CR5       = 11'h00d;
  localparam logic [10:0] IDX_PAL_LAST  = 11'h0ff;
  localparam logic [10:0] IDX_OVL_BASE  = 11'h100;
  localparam logic [10:0] IDX_AUTO_LO   = 11'h200;
  localparam logic [10:0] IDX_AUTO_HI   = 11'h204;
  localparam logic [10:0] IDX_CCOL_LO   = 11'h303;
  localparam logic [10:0] IDX_CCOL_HI   = 11'h304;
  localparam logic [10:0] IDX_CURSOR_LO = 11'h400;

  // ==========================================================
  // Reset values and fields
  localparam logic [9:0] REG8_MASK  = 10'h0ff;
  localparam logic [9:0] MODE_RST   = 10'h0ff;
  localparam logic [9:0] CR2_RST    = 10'h0ff;
  localparam logic [9:0] CR3_RST    = 10'h0ff;
  localparam logic [9:0] CR_ZERO    = 10'h000;
  localparam int MODE_SEQ_RESTART = 0;
  localparam int MODE_DEPTH       = 1;
  localparam int MODE_WIDTH       = 2;
  localparam int MODE_CAL         = 5;
  localparam int MODE_MATCH_LO    = 6;
  localparam int MODE_MATCH_HI    = 7;
  localparam int CR1_HI_BYTE      = 3;
  localparam int CR3_PRG_LO       = 0;
  localparam int CR3_PRG_HI       = 1;
  localparam int CR3_MUX_LO       = 6;
  localparam int CR3_MUX_HI       = 7;
  localparam logic [2:0] SEQ_PATTERN = 3'h5;
  localparam logic [5:0] POR_PRG_DIV  = 6'h20;
  localparam logic [5:0] POR_LOAD_DIV = 6'h04;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SEL_INDEX   = 2'h0,
    SEL_PALETTE = 2'h1,
    SEL_CONTROL = 2'h2,
    SEL_MODE    = 2'h3
  } reg_sel_t;

  typedef enum logic [1:0] {
    COL_RED   = 2'h0,
    COL_GREEN = 2'h1,
    COL_BLUE  = 2'h3
  } col_ptr_t;

  typedef struct packed {
    logic       ce_n;
    reg_sel_t   sel;
    logic       rd_wr_n;
    logic [9:0] data;
  } host_pins_t;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } pixel_t;

  // Divide ratio for the programmable clock output
  function automatic logic [5:0] prg_div(input logic [1:0] code);
    prg_div = 6'(6'h04 << code);
  endfunction

  // Divide ratio for the load clock output from the multiplex mode
  function automatic logic [5:0] load_div(input logic [1:0] code);
    unique case (code)
      2'h0:    load_div = 6'h01;
      2'h1:    load_div = 6'h02;
      2'h2:    load_div = 6'h08;
      default: load_div = 6'h04;
    endcase
  endfunction

endpackage

//--- verification/host_model.sv
// Host bus master model for the palette converter register port.
// Assumes the port's clk; pins change just after the falling edge.
`timescale 1ns/1ns
`default_nettype none
module host_model import dac_port_pkg::*; (
  input  wire logic       clk,
  input  wire logic [9:0] data_out,
  input  wire logic       data_oe_n,
  output var host_pins_t  host_out
);
  // ==========================================================
  // Strobed access
  initial host_out = '{1'b1, SEL_INDEX, 1'b1, 10'h2aa};

  // Released data lines show the inverse of their last level
  task automatic acc(input reg_sel_t s, input logic rd,
                     input logic [9:0] wd, output logic [9:0] rdat);
    @(negedge clk);
    host_out = '{1'b0, s, rd, rd ? ~host_out.data : wd};
    repeat (6) @(negedge clk);
    rdat = data_oe_n ? 10'hx : data_out;
    host_out = '{1'b1, s, rd, ~host_out.data};
    repeat (6) @(negedge clk);
  endtask
endmodule
`default_nettype wire

//--- verification/dac_port_chk.sv
// Checker for the palette converter host register port.
// Sees only the top module's ports; bound below.
`timescale 1ns/1ns
`default_nettype none
module dac_port_chk import dac_port_pkg::*; (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire host_pins_t host_in,
  input wire logic [1:0] palette_sel_in,
  input wire pixel_t     pixel_in,
  input wire logic [9:0] data_out,
  input wire logic       data_oe_n,
  input wire logic       video_enable,
  input wire logic       seq_restart,
  input wire logic       cal_start,
  input wire logic       dac_depth_sel,
  input wire logic [5:0] prog_clock_div,
  input wire logic [5:0] load_clock_div,
  input wire pixel_t     pixel_masked
);
  // ==========================================================
  // Cycles since reset release, saturating
  logic [3:0] por_cnt_q;
  logic [3:0] por_cnt_d;
  always_comb por_cnt_d = (por_cnt_q == 4'hf) ? 4'hf : por_cnt_q + 4'h1;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) por_cnt_q <= 4'h0;
    else por_cnt_q <= por_cnt_d;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ==========================================================
  // Properties
  a_rd_drives: assert property (
    $fell(host_in.ce_n) && host_in.rd_wr_n |-> ##[2:4] !data_oe_n)
    else $error("read strobe not answered");
  a_rd_release: assert property (
    $rose(host_in.ce_n) |-> ##5 data_oe_n)
    else $error("data bus not released");
  a_wr_quiet: assert property (
    !host_in.rd_wr_n [*6] |-> data_oe_n)
    else $error("bus driven during write");
  a_por_hold: assert property (
    por_cnt_q < 4'h8 |-> seq_restart && prog_clock_div == 6'h20
      && load_clock_div == 6'h04)
    else $error("internal reset state wrong");
  a_por_end: assert property (
    por_cnt_q == 4'hd |-> !seq_restart)
    else $error("internal reset too long");
  a_depth_cause: assert property (
    $changed(dac_depth_sel) |-> host_in.sel == SEL_MODE
      && !host_in.rd_wr_n)
    else $error("depth changed without mode write");
  a_cal_pulse: assert property (
    cal_start |-> host_in.sel == SEL_MODE && !host_in.rd_wr_n
      ##1 !cal_start)
    else $error("calibrate pulse wrong");
  a_seq_pulse: assert property (
    $rose(seq_restart) |-> host_in.sel == SEL_MODE && !host_in.rd_wr_n
      ##1 !seq_restart)
    else $error("restart pulse wrong");
  a_mask_subset: assert property (
    (pixel_masked & ~$past(pixel_in)) == 24'h0)
    else $error("masked pixel has extra bits");

  c_read: cover property (!data_oe_n);
  c_cal: cover property (cal_start);
  c_seq: cover property ($rose(seq_restart));
endmodule
bind palette_dac_host_register_port dac_port_chk i_chk (.*);
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench: register, palette and index walks on the host port.
// Assumes host_model as bus master and dac_port_chk bound to the port.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin \
  check_count++; \
  if ((a) !== (e)) begin \
    miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); \
  end \
end
module testbench import dac_port_pkg::*; ;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary value
  localparam logic [10:0] CI [7] = '{11'h003, 11'h004, 11'h005,
    11'h006, 11'h007, 11'h008, 11'h00d};
  localparam logic [9:0] CV [7] = '{{2'h0, ID}, 10'h000, 10'h000,
    10'h0ff, 10'h0ff, 10'h000, 10'h000};
  logic       clk;
  logic       arst_n;
  host_pins_t host_in;
  logic [1:0] palette_sel_in;
  pixel_t     pixel_in;
  pixel_t     pixel_masked;
  logic [9:0] data_out;
  logic [9:0] r;
  logic [5:0] prog_clock_div, load_clock_div;
  logic       data_oe_n, video_enable, seq_restart, cal_start, dac_depth_sel;
  int         miscompares = 0;
  int         check_count = 0;
  int         seq_cnt, cal_cnt, k;

  palette_dac_host_register_port #(.ID_CODE(ID)) i_dut (
    .clk(clk), .arst_n(arst_n), .host_in(host_in),
    .palette_sel_in(palette_sel_in), .pixel_in(pixel_in),
    .data_out(data_out), .data_oe_n(data_oe_n),
    .video_enable(video_enable), .seq_restart(seq_restart),
    .cal_start(cal_start), .dac_depth_sel(dac_depth_sel),
    .prog_clock_div(prog_clock_div), .load_clock_div(load_clock_div),
    .pixel_masked(pixel_masked));
  host_model i_host (.clk(clk), .data_out(data_out),
    .data_oe_n(data_oe_n), .host_out(host_in));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(negedge clk) begin
    seq_cnt += int'(seq_restart === 1'b1);
    cal_cnt += int'(cal_start === 1'b1);
  end

  // ==========================================================
  // Access tasks
  task automatic wr(input reg_sel_t s, input logic [9:0] d);
    i_host.acc(s, 1'b0, d, r);
  endtask
  task automatic rdc(input reg_sel_t s, input logic [9:0] e);
    i_host.acc(s, 1'b1, 10'h000, r);
    `CHK(r, e)
  endtask
  task automatic idx(input logic [10:0] a, input logic hi);
    wr(SEL_INDEX, {2'h0, a[7:0]});
    if (hi) wr(SEL_INDEX, {7'h00, a[10:8]});
  endtask
  task automatic ctlc(input logic [10:0] a, input logic [9:0] e);
    idx(a, 1'b0);
    rdc(SEL_CONTROL, e);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  function automatic logic [9:0] pv(input int n);
    return 10'(n * 137 + 515);
  endfunction
  task automatic results;
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #500_000;
    miscompares++;
    results();
  end

  // ==========================================================
  // Tests
  initial begin
    arst_n = 1'b0;
    palette_sel_in = 2'h3;
    pixel_in = 24'h0;
    wait_n(8);
    `CHK(seq_restart, 1'b1)
    arst_n = 1'b1;
    wait_n(14);
    `CHK({prog_clock_div, load_clock_div}, 12'h804)
    `CHK({video_enable, dac_depth_sel}, 2'h3)
    seq_cnt = 0;
    cal_cnt = 0;
    rdc(SEL_INDEX, 10'h000);
    rdc(SEL_MODE, 10'h0ff);
    for (k = 0; k < 7; k++) ctlc(CI[k], CV[k]);
    idx(IDX_ID, 1'b0);
    wr(SEL_CONTROL, 10'h0a5);
    ctlc(IDX_ID, {2'h0, ID});
    idx(IDX_MASK, 1'b0);
    wr(SEL_CONTROL, 10'h0a5);
    rdc(SEL_CONTROL, 10'h0a5);
    pixel_in = 24'hff3c81;
    wait_n(3);
    `CHK(pixel_masked, 24'ha52481)
    idx(11'h0fe, 1'b0);
    wr(SEL_PALETTE, 10'h3ff);
    idx(11'h0fe, 1'b0);
    for (k = 0; k < 6; k++) wr(SEL_PALETTE, pv(k));
    rdc(SEL_INDEX, 10'h000);
    idx(11'h0fe, 1'b0);
    for (k = 0; k < 6; k++) rdc(SEL_PALETTE, pv(k));
    rdc(SEL_INDEX, 10'h000);
    wr(SEL_MODE, 10'h3c7);
    rdc(SEL_MODE, 10'h0c7);
    wr(SEL_MODE, 10'h0c6);
    wr(SEL_MODE, 10'h0c7);
    wr(SEL_MODE, 10'h0e7);
    `CHK({seq_cnt, cal_cnt}, {32'd1, 32'd1})
    palette_sel_in = 2'h2;
    wait_n(6);
    `CHK(video_enable, 1'b0)
    palette_sel_in = 2'h3;
    wait_n(6);
    `CHK(video_enable, 1'b1)
    wr(SEL_MODE, 10'h0c5);
    `CHK(dac_depth_sel, 1'b0)
    wr(SEL_MODE, 10'h0c7);
    idx(IDX_CR1, 1'b0);
    wr(SEL_CONTROL, 10'h308);
    rdc(SEL_CONTROL, 10'h008);
    idx(11'h101, 1'b1);
    for (k = 0; k < 3; k++) wr(SEL_PALETTE, pv(k + 9));
    rdc(SEL_INDEX, 10'h002);
    rdc(SEL_INDEX, 10'h001);
    idx(11'h101, 1'b1);
    for (k = 0; k < 3; k++) rdc(SEL_PALETTE, pv(k + 9));
    wr(SEL_INDEX, 10'h055);
    rdc(SEL_INDEX, 10'h055);
    rdc(SEL_INDEX, 10'h001);
    idx(11'h200, 1'b1);
    wr(SEL_CONTROL, 10'h000);
    rdc(SEL_INDEX, 10'h001);
    rdc(SEL_INDEX, 10'h002);
    idx(11'h7ff, 1'b1);
    wr(SEL_CONTROL, 10'h000);
    rdc(SEL_INDEX, 10'h000);
    rdc(SEL_INDEX, 10'h000);
    wr(SEL_MODE, 10'h0c3);
    idx(11'h010, 1'b1);
    for (k = 0; k < 3; k++) begin
      wr(SEL_PALETTE, 10'h3ad);
      wr(SEL_PALETTE, 10'h003);
    end
    idx(11'h010, 1'b1);
    for (k = 0; k < 6; k++) rdc(SEL_PALETTE, k[0] ? 10'h003 : 10'h0ad);
    idx(IDX_CR3, 1'b1);
    wr(SEL_CONTROL, 10'h000);
    `CHK({prog_clock_div, load_clock_div}, 12'h101)
    results();
  end
endmodule
`default_nettype wire
